/* core/fsw_pkg.sv */
// Package with constants and carrier types of the fail-safe and development mode controller.
package fsw_pkg;
    // -------------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------------
    localparam int unsigned CLK_HZ             = 100_000_000;
    localparam int unsigned FILTER_MS          = 100;
    localparam int unsigned TSD_EXIT_MS        = 1000;
    localparam int unsigned WAKE_FILTER_US     = 16;
    localparam int unsigned TEST_TIME_US       = 10;
    localparam int unsigned RESET_DELAY_US     = 10;
    localparam int unsigned FILTER_CYCLES      = (CLK_HZ / 1000) * FILTER_MS;
    localparam int unsigned TSD_EXIT_CYCLES    = (CLK_HZ / 1000) * TSD_EXIT_MS;
    localparam int unsigned WAKE_FILTER_CYCLES = (CLK_HZ / 1_000_000) * WAKE_FILTER_US;
    localparam int unsigned TEST_TIME_CYCLES   = (CLK_HZ / 1_000_000) * TEST_TIME_US;
    localparam int unsigned RESET_DELAY_CYCLES = (CLK_HZ / 1_000_000) * RESET_DELAY_US;
    localparam int unsigned UV_LIMIT           = 4;

    // -------------------------------------------------------------------------
    // Field encodings and reset values
    // -------------------------------------------------------------------------
    localparam logic [1:0] DEVICE_STATUS_FIELD_RESET   = 2'h0;
    localparam logic [1:0] DEVICE_STATUS_FIELD_FAIL    = 2'h1;
    localparam logic [1:0] DEVICE_STATUS_FIELD_SLEEP   = 2'h2;
    localparam logic [1:0] WATCHDOG_FAILURE_FIELD_NONE     = 2'h0;
    localparam logic [1:0] WATCHDOG_FAILURE_FIELD_ONE      = 2'h1;
    localparam logic [1:0] WATCHDOG_FAILURE_FIELD_TWO      = 2'h2;
    localparam logic [2:0] WAKE_SRC_DEFAULT = 3'h7;
    localparam logic [2:0] WAKE_SRC_MEASURE = 3'h4;

    typedef enum logic [2:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } fsw_mode_type;

    // Supply and failure causes, all levels in the system clock domain.
    typedef struct packed {
        logic thermal_shutdown_level2;
        logic main_overvoltage;
        logic main_short;
        logic main_undervoltage;
        logic battery_above_uv;
        logic watchdog_bad_trigger;
    } fsw_cause_type;

    typedef struct packed {
        logic [1:0] device_status_field;
        logic [1:0] watchdog_failure_field;
        logic       failure_flag;
        logic       thermal_flag;
        logic       main_undervoltage_flag;
        logic       main_undervoltage_failsafe_flag;
        logic       main_overvoltage_flag;
        logic       main_short_flag;
    } fsw_status_type;

    typedef struct packed {
        logic       main_regulator_on;
        logic       auxiliary_regulator_on;
        logic       transceivers_on;
        logic       transceivers_wake_capable;
        logic       high_side_on;
        logic       fail_outputs;
        logic       cyclic_enable;
        logic       reset_output_n;
        logic       interrupt_n;
        logic       watchdog_run;
        logic [2:0] wake_sources;
    } fsw_drive_type;
endpackage

/* core/fsw_control.sv */
// Fail-safe, development mode and cyclic sense wake controller.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Level-two thermal shutdown always forces fail-safe mode.
// - Main overvoltage forces fail-safe only if reset enable set and restart select zero.
// - Bad watchdog triggers force fail-safe at first (count bit one) or second.
// - Main regulator short to ground forces fail-safe mode.
// - Four consecutive main undervoltages, counted while battery is fine, force fail-safe; the count only clears on fail-safe entry or reset.
// - Fail-safe entry arms default wakes, clears wake status, turns off drivers and regulators.
// - Wake pins in measurement function stay there and are not armed.
// - Fail-safe lasts at least 100 ms; stored wakes lead to restart afterwards.
// - Thermal fail-safe exits to restart after 1 s without wake.
// - Fail outputs activate in fail-safe and stay active afterwards.
// - Fail-safe disables cyclic functions; static wake filter 16 us; transceivers wake capable.
// - Fail-safe sets failure flag; device status reads 01 after return.
// - Watchdog fail-safe reports failure field 01 for one, 10 for two.
// - Cause flags: thermal, short plus undervoltage, four undervoltages, overvoltage.
// - Development mode stops the watchdog entirely.
// - Development mode ignores watchdog failures; other causes remain valid.
// - Development mode defaults transceivers and auxiliary regulator on in init.
// - Test pin low in init plus SPI command latches development; high too long refuses.
// - Development mode holds until power-on reset.
// - Cyclic sense holds high side on while enabled; edge in on-time interrupts or wakes.
// - Restart holds reset output low, releases after reset delay into normal.
module fsw_control #(
    parameter int unsigned FILTER_COUNT   = fsw_pkg::FILTER_CYCLES,
    parameter int unsigned TSD_EXIT_COUNT = fsw_pkg::TSD_EXIT_CYCLES
) (
    input  wire logic           clk,
    input  wire logic           resetn,
    input  wire logic           sense_clk,
    input  wire fsw_pkg::fsw_cause_type causes,
    input  wire logic           main_overvoltage_reset_enable,
    input  wire logic           restart_select_config,
    input  wire logic           watchdog_count_config,
    input  wire logic           wake_pin_measure_select,
    input  wire logic           spi_command,
    input  wire logic           sleep_request,
    input  wire logic           stop_request,
    input  wire logic           test_entry_pin,
    input  wire logic [2:0]     wake_input_pin,
    input  wire logic           bus_wake,
    input  wire logic           cyclic_sense_enable,
    input  wire logic [7:0]     first_timer_control,
    input  wire logic [7:0]     second_timer_control,
    output fsw_pkg::fsw_mode_type   mode,
    output fsw_pkg::fsw_status_type status,
    output fsw_pkg::fsw_drive_type  drive,
    output logic                    development_mode,
    output logic [2:0]              wake_status_first
);
    // -------------------------------------------------------------------------
    // Link domain: cyclic sense runs on its own slow clock.
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  en_s1;
        logic [2:0]  en_s2;
        logic [2:0]  pin_s1;
        logic [2:0]  pin_s2;
        logic [7:0]  count;
        logic [15:0] timer_s1;
        logic [15:0] timer_cfg;
        logic        on_time;
        logic [2:0]  ref_level;
        logic        edge_toggle;
    } fsw_link_type;

    fsw_link_type link;
    fsw_link_type next_link;
    logic         link_rst_s1;
    logic         link_rst_n;

    // Reset is taken into the link domain through two flip-flops.
    always_ff @(posedge sense_clk) begin
        link_rst_s1 <= resetn;
        link_rst_n  <= link_rst_s1;
    end

    always_comb begin
        next_link        = link;
        next_link.en_s1  = {3{drive.cyclic_enable}};
        next_link.en_s2  = link.en_s1;
        next_link.pin_s1 = wake_input_pin;
        next_link.pin_s2 = link.pin_s1;
        next_link.timer_s1 = {first_timer_control, second_timer_control};
        // Settings are taken over only while cyclic sense is idle, so a running cycle never sees a torn word.
        if (!link.en_s2[0]) begin
            next_link.timer_cfg = link.timer_s1;
        end
        next_link.count  = link.count + 8'h01;
        if (link.count >= link.timer_cfg[15:8]) begin
            next_link.count = 8'h00;
        end
        next_link.on_time = link.en_s2[0] && (link.count < link.timer_cfg[7:0]);
        if (link.on_time) begin
            if (link.pin_s2 != link.ref_level) begin
                next_link.edge_toggle = ~link.edge_toggle;
            end
            next_link.ref_level = link.pin_s2;
        end
        if (!link_rst_n) begin
            next_link = '0;
        end
    end

    always_ff @(posedge sense_clk) begin
        link <= next_link;
    end

    // -------------------------------------------------------------------------
    // System domain state.
    // -------------------------------------------------------------------------
    typedef struct packed {
        fsw_pkg::fsw_mode_type   mode;
        fsw_pkg::fsw_status_type status;
        fsw_pkg::fsw_drive_type  drive;
        logic                    dev_mode;
        logic                    dev_refused;
        logic [15:0]             test_high_count;
        logic [2:0]              wake_status;
        logic [2:0]              uv_count;
        logic                    uv_prev;
        logic                    wd_seen;
        logic                    tsd_cause;
        logic                    wake_stored;
        logic [31:0]             timer;
        logic [15:0]             rst_timer;
        logic [15:0]             wake_filt;
        logic [2:0]              pin_s1;
        logic [2:0]              pin_s2;
        logic [2:0]              pin_prev;
        logic                    test_s1;
        logic                    test_s2;
        logic [2:0]              tog_s;
        logic                    tog_seen;
    } fsw_state_type;

    fsw_state_type st;
    fsw_state_type next_st;
    logic          fail_entry;
    logic          watchdog_failure_field_event;
    logic          cyclic_edge;

    assign mode              = st.mode;
    assign status            = st.status;
    assign drive             = st.drive;
    assign development_mode  = st.dev_mode;
    assign wake_status_first = st.wake_status;

    always_comb begin
        next_st = st;
        // Inputs from pins pass two flip-flops first, the toggle from the link domain three.
        next_st.pin_s1   = wake_input_pin;
        next_st.pin_s2   = st.pin_s1;
        next_st.pin_prev = st.pin_s2;
        next_st.test_s1  = test_entry_pin;
        next_st.test_s2  = st.test_s1;
        next_st.tog_s    = {st.tog_s[1:0], link.edge_toggle};
        next_st.tog_seen = st.tog_s[2];
        cyclic_edge      = st.tog_s[2] != st.tog_seen;

        // Bad watchdog triggers count only outside development mode.
        watchdog_failure_field_event = 1'b0;
        if (causes.watchdog_bad_trigger && !st.dev_mode && st.mode != fsw_pkg::MODE_FAILSAFE) begin
            if (watchdog_count_config || st.wd_seen) begin
                watchdog_failure_field_event = 1'b1;
            end else begin
                next_st.wd_seen = 1'b1;
            end
        end

        // Undervoltage events are counted on rising edges while battery is good.
        next_st.uv_prev = causes.main_undervoltage;
        if (causes.main_undervoltage && !st.uv_prev && causes.battery_above_uv) begin
            next_st.uv_count = st.uv_count + 3'h1;
        end
        if (st.mode == fsw_pkg::MODE_NORMAL && !causes.main_undervoltage && st.uv_prev) begin
            next_st.uv_count = st.uv_count;
        end

        fail_entry = st.mode != fsw_pkg::MODE_FAILSAFE && (
                     causes.thermal_shutdown_level2
                     || (causes.main_overvoltage && main_overvoltage_reset_enable && !restart_select_config)
                     || watchdog_failure_field_event
                     || causes.main_short
                     || st.uv_count >= 3'(fsw_pkg::UV_LIMIT));

        // Static wake with filter: a high level on an armed pin held stable for the filter time is a wake.
        if (st.pin_s2 != st.pin_prev) begin
            next_st.wake_filt = 16'h0000;
        end else if (st.wake_filt < 16'(fsw_pkg::WAKE_FILTER_CYCLES)) begin
            next_st.wake_filt = st.wake_filt + 16'h0001;
        end

        case (st.mode)
            fsw_pkg::MODE_INIT: begin
                next_st.drive.transceivers_on        = st.dev_mode;
                next_st.drive.auxiliary_regulator_on = st.dev_mode;
                if (st.test_s2) begin
                    if (st.test_high_count >= 16'(fsw_pkg::TEST_TIME_CYCLES)) begin
                        next_st.dev_refused = 1'b1;
                    end else begin
                        next_st.test_high_count = st.test_high_count + 16'h0001;
                    end
                end
                if (spi_command) begin
                    if (!st.test_s2 && !st.dev_refused) begin
                        next_st.dev_mode = 1'b1;
                        next_st.drive.transceivers_on        = 1'b1;
                        next_st.drive.auxiliary_regulator_on = 1'b1;
                        next_st.drive.watchdog_run           = 1'b0;
                    end
                    next_st.mode = fsw_pkg::MODE_NORMAL;
                end
            end
            fsw_pkg::MODE_NORMAL, fsw_pkg::MODE_STOP: begin
                if (stop_request) begin
                    next_st.mode = fsw_pkg::MODE_STOP;
                end
                if (sleep_request) begin
                    next_st.mode = fsw_pkg::MODE_SLEEP;
                    next_st.drive.main_regulator_on = 1'b0;
                end
                if (cyclic_edge) begin
                    next_st.drive.interrupt_n = 1'b0;
                end else begin
                    next_st.drive.interrupt_n = 1'b1;
                end
            end
            fsw_pkg::MODE_SLEEP: begin
                if (cyclic_edge || bus_wake) begin
                    next_st.mode = fsw_pkg::MODE_RESTART;
                end
            end
            fsw_pkg::MODE_FAILSAFE: begin
                next_st.timer = st.timer + 32'h0000_0001;
                if ((st.wake_filt == 16'(fsw_pkg::WAKE_FILTER_CYCLES) && st.pin_s2 != 3'h0
                     && (st.pin_s2 & st.drive.wake_sources) != 3'h0) || bus_wake || cyclic_edge) begin
                    next_st.wake_stored = 1'b1;
                    next_st.wake_status = st.wake_status | (st.pin_s2 & st.drive.wake_sources);
                end
                if (st.tsd_cause && st.timer >= 32'(TSD_EXIT_COUNT) - 32'h0000_0001) begin
                    next_st.mode = fsw_pkg::MODE_RESTART;
                end else if (st.wake_stored && st.timer >= 32'(FILTER_COUNT) - 32'h0000_0001) begin
                    next_st.mode = fsw_pkg::MODE_RESTART;
                end
            end
            fsw_pkg::MODE_RESTART: begin
                next_st.drive.main_regulator_on = 1'b1;
                next_st.drive.reset_output_n    = 1'b0;
                next_st.rst_timer = st.rst_timer + 16'h0001;
                if (st.rst_timer >= 16'(fsw_pkg::RESET_DELAY_CYCLES) - 16'h0001) begin
                    next_st.mode = fsw_pkg::MODE_NORMAL;
                    next_st.drive.reset_output_n = 1'b1;
                    next_st.drive.watchdog_run   = !st.dev_mode;
                    next_st.drive.transceivers_on = 1'b1;
                    next_st.drive.transceivers_wake_capable = 1'b0;
                end
            end
            default: begin
                next_st.mode = fsw_pkg::MODE_INIT;
            end
        endcase

        if (st.mode != fsw_pkg::MODE_RESTART) begin
            next_st.rst_timer = 16'h0000;
        end
        if (st.dev_mode) begin
            next_st.drive.watchdog_run = 1'b0;
            next_st.dev_mode           = 1'b1;
        end

        if (fail_entry) begin
            next_st.mode        = fsw_pkg::MODE_FAILSAFE;
            next_st.timer       = 32'h0000_0000;
            next_st.wake_stored = 1'b0;
            next_st.tsd_cause   = causes.thermal_shutdown_level2;
            next_st.wake_status = 3'h0;
            next_st.uv_count    = 3'h0;
            next_st.wd_seen     = 1'b0;
            next_st.drive.wake_sources = wake_pin_measure_select ? fsw_pkg::WAKE_SRC_MEASURE
                                                                 : fsw_pkg::WAKE_SRC_DEFAULT;
            next_st.drive.main_regulator_on         = 1'b0;
            next_st.drive.auxiliary_regulator_on    = 1'b0;
            next_st.drive.transceivers_on           = 1'b0;
            next_st.drive.high_side_on              = 1'b0;
            next_st.drive.transceivers_wake_capable = 1'b1;
            next_st.drive.cyclic_enable             = 1'b0;
            next_st.drive.watchdog_run              = 1'b0;
            next_st.drive.interrupt_n               = 1'b1;
            next_st.drive.fail_outputs              = 1'b1;
            next_st.status.failure_flag        = 1'b1;
            next_st.status.device_status_field = fsw_pkg::DEVICE_STATUS_FIELD_FAIL;
            if (watchdog_failure_field_event) begin
                next_st.status.watchdog_failure_field = watchdog_count_config ? fsw_pkg::WATCHDOG_FAILURE_FIELD_ONE
                                                                              : fsw_pkg::WATCHDOG_FAILURE_FIELD_TWO;
            end
            if (causes.thermal_shutdown_level2) begin
                next_st.status.thermal_flag = 1'b1;
            end
            if (causes.main_short) begin
                next_st.status.main_short_flag        = 1'b1;
                next_st.status.main_undervoltage_flag = 1'b1;
            end
            if (st.uv_count >= 3'(fsw_pkg::UV_LIMIT)) begin
                next_st.status.main_undervoltage_flag          = 1'b1;
                next_st.status.main_undervoltage_failsafe_flag = 1'b1;
            end
            if (causes.main_overvoltage && main_overvoltage_reset_enable && !restart_select_config) begin
                next_st.status.main_overvoltage_flag = 1'b1;
            end
        end else if (st.mode == fsw_pkg::MODE_NORMAL || st.mode == fsw_pkg::MODE_STOP) begin
            next_st.drive.cyclic_enable = cyclic_sense_enable;
            next_st.drive.high_side_on  = cyclic_sense_enable;
        end

        if (!resetn) begin
            next_st = '0;
            next_st.mode                        = fsw_pkg::MODE_INIT;
            next_st.drive.main_regulator_on     = 1'b1;
            next_st.drive.reset_output_n        = 1'b1;
            next_st.drive.interrupt_n           = 1'b1;
            next_st.drive.watchdog_run          = 1'b1;
            next_st.drive.wake_sources          = fsw_pkg::WAKE_SRC_DEFAULT;
            next_st.status.device_status_field  = fsw_pkg::DEVICE_STATUS_FIELD_RESET;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // -------------------------------------------------------------------------
    // Checks.
    // -------------------------------------------------------------------------
    property p_thermal_entry;
        @(posedge clk) disable iff (!resetn)
        (causes.thermal_shutdown_level2 && st.mode != fsw_pkg::MODE_FAILSAFE) |=> st.mode == fsw_pkg::MODE_FAILSAFE;
    endproperty
    a_thermal_entry: assert property (p_thermal_entry) else $error("thermal shutdown did not enter fail-safe");

    property p_ov_gate;
        @(posedge clk) disable iff (!resetn)
        (st.mode == fsw_pkg::MODE_NORMAL && causes.main_overvoltage && restart_select_config && !causes.thermal_shutdown_level2
         && !causes.main_short && !causes.watchdog_bad_trigger && st.uv_count < 3'h4) |=> st.mode != fsw_pkg::MODE_FAILSAFE;
    endproperty
    a_ov_gate: assert property (p_ov_gate) else $error("overvoltage entered fail-safe while restart selected");

    property p_short_flags;
        @(posedge clk) disable iff (!resetn)
        (causes.main_short && st.mode != fsw_pkg::MODE_FAILSAFE) |=>
            st.status.main_short_flag && st.status.main_undervoltage_flag && st.drive.fail_outputs;
    endproperty
    a_short_flags: assert property (p_short_flags) else $error("short to ground flags missing");

    property p_entry_off;
        @(posedge clk) disable iff (!resetn)
        $rose(st.mode == fsw_pkg::MODE_FAILSAFE) |->
            !st.drive.main_regulator_on && !st.drive.auxiliary_regulator_on && !st.drive.high_side_on
            && st.wake_status == 3'h0 && !st.drive.cyclic_enable;
    endproperty
    a_entry_off: assert property (p_entry_off) else $error("supplies or drivers on after fail-safe entry");

    property p_min_filter;
        @(posedge clk) disable iff (!resetn)
        (st.mode == fsw_pkg::MODE_FAILSAFE && st.timer < 32'(FILTER_COUNT) - 32'h0000_0001) |=>
            st.mode == fsw_pkg::MODE_FAILSAFE;
    endproperty
    a_min_filter: assert property (p_min_filter) else $error("fail-safe left before filter time");

    property p_fail_outputs_hold;
        @(posedge clk) disable iff (!resetn)
        st.drive.fail_outputs |=> st.drive.fail_outputs;
    endproperty
    a_fail_outputs_hold: assert property (p_fail_outputs_hold) else $error("fail outputs released");

    property p_dev_hold;
        @(posedge clk) disable iff (!resetn)
        st.dev_mode |=> st.dev_mode && !st.drive.watchdog_run;
    endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("development mode lost or watchdog running");

    property p_restart_release;
        @(posedge clk) disable iff (!resetn)
        $rose(st.mode == fsw_pkg::MODE_RESTART) |=> !st.drive.reset_output_n [*8];
    endproperty
    a_restart_release: assert property (p_restart_release) else $error("reset output released too early");
endmodule

`default_nettype wire

/* bench/fsw_mcu_model.sv */
// Microcontroller side model: test entry pin level and the command that leaves init.
`timescale 1ns/1ps
`default_nettype none
module fsw_mcu_model (
    input  wire logic clk,
    output logic      spi_command,
    output logic      test_entry_pin
);
    initial begin
        spi_command    = 1'b0;
        test_entry_pin = 1'b0;
    end
    // The pin level is held for the whole init span so the sampler sees a settled level.
    task automatic leave_init(input logic level, input int hold);
        test_entry_pin <= level;
        repeat (hold) @(posedge clk);
        spi_command <= 1'b1;
        @(posedge clk);
        spi_command <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* bench/fsw_control_tb_top.sv */
// Self-checking testbench of the fail-safe and development mode controller.
`timescale 1ns/1ps
`default_nettype none
module fsw_control_tb_top;
    localparam int unsigned FC = 200;
    logic                    clk = 1'b0, sense_clk = 1'b0, resetn = 1'b0;
    fsw_pkg::fsw_cause_type  c = 6'h02;
    logic                    ov_en = 1'b1, rsel = 1'b0, wdc = 1'b0, meas = 1'b0, cyc = 1'b0, bwk = 1'b0;
    fsw_pkg::fsw_mode_type   mode;
    fsw_pkg::fsw_status_type st;
    fsw_pkg::fsw_drive_type  dr;
    logic                    dev, spi, tpin, slp = 1'b0, stp = 1'b0;
    logic [2:0]              wst, wk = 3'h0;
    logic [5:0]              cz [4] = '{6'h03, 6'h12, 6'h0a, 6'h06};
    logic [7:0]              cs [4] = '{8'ha0, 8'h22, 8'h29, 8'h2c};
    int                      cn [4] = '{2, 1, 1, 4};
    int                      bad_count = 0, n_checks = 0, n;
    always #5 clk = ~clk;
    // The link clock starts off phase so its edges never line up with the system clock.
    initial #7 forever #15 sense_clk = ~sense_clk;
    fsw_mcu_model mcu_u (.clk(clk), .spi_command(spi), .test_entry_pin(tpin));
    fsw_control #(.FILTER_COUNT(FC), .TSD_EXIT_COUNT(2 * FC)) dut_u (
        .clk(clk), .resetn(resetn), .sense_clk(sense_clk), .causes(c),
        .main_overvoltage_reset_enable(ov_en), .restart_select_config(rsel), .watchdog_count_config(wdc),
        .wake_pin_measure_select(meas), .spi_command(spi), .sleep_request(slp), .stop_request(stp),
        .test_entry_pin(tpin), .wake_input_pin(wk), .bus_wake(bwk), .cyclic_sense_enable(cyc),
        .first_timer_control(8'h09), .second_timer_control(8'h03), .mode(mode), .status(st),
        .drive(dr), .development_mode(dev), .wake_status_first(wst));
    // -------------------------------------------------------------------------
    // Access tasks
    // -------------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rst();
        @(posedge clk) resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic pulse(input logic [5:0] cc, input int k);
        repeat (k) begin
            @(posedge clk) c <= cc;
            @(posedge clk) c <= 6'h02;
        end
    endtask
    task automatic wait_mode(input fsw_pkg::fsw_mode_type m);
        n = 0;
        while (mode !== m && n < 3000) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #200_000;
        bad_count++;
        end_sim();
    end
    initial begin
        rst();
        mcu_u.leave_init(1'b0, 3);
        @(negedge clk);
        chk(mode, fsw_pkg::MODE_NORMAL);
        chk({dev, dr.auxiliary_regulator_on, dr.transceivers_on, dr.watchdog_run}, 4'he);
        @(posedge clk) cyc <= 1'b1;
        pulse(6'h03, 2);
        @(negedge clk);
        chk(mode, fsw_pkg::MODE_NORMAL);
        @(posedge clk) wk <= 3'h1;
        n = 0;
        while (dr.interrupt_n !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(n < 200, 1'b1);
        pulse(6'h22, 1);
        @(negedge clk);
        chk(mode, fsw_pkg::MODE_FAILSAFE);
        chk({st.failure_flag, st.thermal_flag, dr.fail_outputs, dr.main_regulator_on, dr.auxiliary_regulator_on,
             dr.high_side_on, dr.cyclic_enable, dr.transceivers_wake_capable}, 8'he1);
        chk(wst, 3'h0);
        wait_mode(fsw_pkg::MODE_RESTART);
        chk(n, 2 * FC);
        wait_mode(fsw_pkg::MODE_NORMAL);
        chk({n >= 1000, dr.reset_output_n, dr.fail_outputs, dev}, 4'hf);
        chk(st.device_status_field, fsw_pkg::DEVICE_STATUS_FIELD_FAIL);
        rst();
        mcu_u.leave_init(1'b1, 1100);
        @(negedge clk);
        chk({dev, dr.auxiliary_regulator_on, dr.transceivers_on, dr.watchdog_run}, 4'h1);
        @(posedge clk) wdc <= 1'b1;
        pulse(6'h03, 1);
        wait_mode(fsw_pkg::MODE_FAILSAFE);
        chk({n < 2, dr.wake_sources}, {1'b1, fsw_pkg::WAKE_SRC_DEFAULT});
        chk(st.watchdog_failure_field, fsw_pkg::WATCHDOG_FAILURE_FIELD_ONE);
        @(posedge clk) bwk <= 1'b1;
        @(posedge clk) bwk <= 1'b0;
        wait_mode(fsw_pkg::MODE_RESTART);
        chk(n + 2 >= FC && n + 2 < FC + 20, 1'b1);
        wait_mode(fsw_pkg::MODE_NORMAL);
        @(posedge clk) stp <= 1'b1;
        @(posedge clk) stp <= 1'b0;
        repeat (100) @(negedge clk);
        chk(mode, fsw_pkg::MODE_STOP);
        @(posedge clk) slp <= 1'b1;
        @(posedge clk) slp <= 1'b0;
        @(negedge clk);
        chk({mode == fsw_pkg::MODE_SLEEP, dr.main_regulator_on}, 2'h2);
        @(posedge clk) wk <= 3'h0;
        wait_mode(fsw_pkg::MODE_RESTART);
        chk(n < 200, 1'b1);
        @(posedge clk) begin
            wdc  <= 1'b0;
            meas <= 1'b1;
        end
        for (int k = 0; k < 4; k++) begin
            rst();
            mcu_u.leave_init(1'b1, 1100);
            pulse(cz[k], cn[k] - 1);
            @(negedge clk);
            chk(mode === fsw_pkg::MODE_FAILSAFE, 1'b0);
            pulse(cz[k], 1);
            wait_mode(fsw_pkg::MODE_FAILSAFE);
            chk(n, (k == 3) ? 2 : 1);
            chk(st[7:0], cs[k]);
            chk(dr.wake_sources, fsw_pkg::WAKE_SRC_MEASURE);
        end
        end_sim();
    end
endmodule
`default_nettype wire
